// ==== design/arf_core_if.sv ====
// carrier between the top and its edge detector and result packer
// assumes: instantiated inside the top, one instance per block
`timescale 1ns/100ps
`default_nettype none

interface arf_core_if #(
  parameter int SRC_N = 16,
  parameter int RES_W = 10
);
  logic [SRC_N-1:0] src;
  logic [SRC_N-1:0] rise;
  logic [RES_W-1:0] value;
  logic             justify;
  logic [7:0]       high;
  logic [7:0]       low;

  modport edge_side (input src, output rise);
  modport top_edge  (output src, input rise);
  modport pack_side (input value, input justify, output high, output low);
  modport top_pack  (output value, output justify, input high, input low);
endinterface

`default_nettype wire

// ==== design/arf_defs.svh ====
// register map, field positions and reset values of the result/trigger block
// assumes: included by bare name from every design file that needs it
`ifndef ARF_DEFS_SVH
`define ARF_DEFS_SVH

// ====================================================================
// register offsets (3-bit address)
`define ARF_ADDR_W        3
`define ARF_OFF_TRIG      3'h0
`define ARF_OFF_RES_HIGH  3'h1
`define ARF_OFF_RES_LOW   3'h2
`define ARF_OFF_FORMAT    3'h3
`define ARF_OFF_STATUS    3'h4

// ====================================================================
// field positions
`define ARF_TRIG_SEL      3:0
`define ARF_FMT_JUSTIFY   7
`define ARF_STAT_BUSY     0
`define ARF_STAT_MISS     1
`define ARF_LJ_HIGH       9:2
`define ARF_LJ_LOW        1:0
`define ARF_RJ_HIGH       9:8
`define ARF_RJ_LOW        7:0

// ====================================================================
// reset values and fill patterns
`define ARF_TRIG_RST      4'h0
`define ARF_JUSTIFY_RST   1'b0
`define ARF_EDGE_PREV_RST 1'b1
`define ARF_PAD4          4'h0
`define ARF_PAD6          6'h00
`define ARF_PAD7          7'h00
`define ARF_DATA_IDLE     8'h00

`endif

// ==== design/arf_edge_detect.sv ====
// per-source rising edge detector for the auto-trigger inputs
// assumes: sources are synchronous to clk
`timescale 1ns/100ps
`default_nettype none
`include "arf_defs.svh"

module arf_edge_detect #(
  parameter int SRC_N = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // sources in, edges out
  arf_core_if.edge_side     eif
);

  logic [SRC_N-1:0] prev;

  // ==================================================================
  // every source keeps its own history, so switching the selector
  // onto a source that is already high gives no false edge
  genvar i;
  generate
    for (i = 0; i < SRC_N; i++) begin : g_src
      // prev resets high: a level already up at release is no edge
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          prev[i] <= `ARF_EDGE_PREV_RST;
        end else begin
          prev[i] <= eif.src[i];
        end
      end
      assign eif.rise[i] = eif.src[i] & ~prev[i];
    end
  endgenerate

endmodule

`default_nettype wire

// ==== design/arf_pkg.sv ====
// types shared by the result/trigger block
// assumes: compiled before every file that names arf_pkg
package arf_pkg;

  // trigger sequencer states, one-hot
  typedef enum logic [1:0] {
    ARF_IDLE = 2'b01,
    ARF_WAIT = 2'b10
  } arf_state_e;

  typedef logic [7:0] arf_byte_t;

endpackage

// ==== design/arf_result_pack.sv ====
// places a 10-bit conversion result into the high and low result bytes
// assumes: purely combinational, the top captures the bytes
`timescale 1ns/100ps
`default_nettype none
`include "arf_defs.svh"

module arf_result_pack (
  // result and format in, bytes out
  arf_core_if.pack_side pif
);

  // ==================================================================
  // left justified: value[9:2] high, value[1:0] at low[7:6]
  // high byte, left
  wire [7:0] lj_high = pif.value[`ARF_LJ_HIGH];
  // top two bits of low byte
  // unused low bits forced to zero
  wire [7:0] lj_low  = {pif.value[`ARF_LJ_LOW], `ARF_PAD6};

  // right justified: value[9:8] at high[1:0], value[7:0] low
  // two bits in high byte
  // unused high bits forced to zero
  wire [7:0] rj_high = {`ARF_PAD6, pif.value[`ARF_RJ_HIGH]};
  wire [7:0] rj_low  = pif.value[`ARF_RJ_LOW];

  // format select: set means right justified
  assign pif.high = pif.justify ? rj_high : lj_high;
  assign pif.low  = pif.justify ? rj_low  : lj_low;

endmodule

`default_nettype wire

// ==== design/arf_result_trigger.sv ====
// converter result formatting and auto-conversion trigger selection
// assumes: one 100 MHz clock, all inputs synchronous to it, a simple
// register port with read data one cycle after the read strobe
//
// Behaviour
// - low four trigger-select bits pick the auto-conversion source
// - upper four trigger-select bits are unimplemented and read zero
// - sources trigger on rising edges; a held level does not retrigger
// - left format: result bits nine to two fill the high byte
// - left format: result bits one, zero go to low bits seven, six
// - left format: low six bits of low byte carry nothing
// - right format: result bits nine, eight go to high bits one, zero
// - right format: high bits seven to two carry nothing
// - right format: result bits seven to zero fill the low byte
// - result bytes are read/write, unknown at power-up, kept over reset
`timescale 1ns/100ps
`default_nettype none
`include "arf_defs.svh"

module arf_result_trigger #(
  parameter int SEL_W = 4,
  parameter int RES_W = 10
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // register port
  input  wire logic [`ARF_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // auto-trigger sources
  input  wire logic [(1<<SEL_W)-1:0] trig_src,
  // converter handshake
  output logic                       conv_start,
  output logic                       conv_busy,
  input  wire logic                  conv_done,
  input  wire logic [RES_W-1:0]      conv_value
);

  localparam int SRC_N = 1 << SEL_W;

  // ==================================================================
  // state
  arf_pkg::arf_state_e state;
  arf_pkg::arf_state_e next_state;
  logic [SEL_W-1:0]    trig_sel;
  logic                justify;
  logic                miss;
  arf_pkg::arf_byte_t  res_high;
  arf_pkg::arf_byte_t  res_low;

  // ==================================================================
  // sub-blocks
  arf_core_if #(.SRC_N(SRC_N), .RES_W(RES_W)) core ();

  // sources and result feed the helpers
  assign core.src     = trig_src;
  assign core.value   = conv_value;
  assign core.justify = justify;

  arf_edge_detect #(.SRC_N(SRC_N)) u_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .eif     (core.edge_side)
  );

  arf_result_pack u_pack (
    .pif (core.pack_side)
  );

  // ==================================================================
  // address decode
  wire hit_trig   = (reg_addr == `ARF_OFF_TRIG);
  wire hit_high   = (reg_addr == `ARF_OFF_RES_HIGH);
  wire hit_low    = (reg_addr == `ARF_OFF_RES_LOW);
  wire hit_format = (reg_addr == `ARF_OFF_FORMAT);
  wire hit_status = (reg_addr == `ARF_OFF_STATUS);
  wire hit_none   = ~(hit_trig | hit_high | hit_low | hit_format | hit_status); // unmapped

  wire wr_trig    = reg_wr & hit_trig;
  wire wr_high    = reg_wr & hit_high;
  wire wr_low     = reg_wr & hit_low;
  wire wr_format  = reg_wr & hit_format;
  wire wr_status  = reg_wr & hit_status;

  // ==================================================================
  // trigger path
  // each source keeps its own history, so moving the selector onto a
  // source that is already high starts nothing
  // selected source edge
  wire sel_rise   = core.rise[trig_sel];
  wire in_idle    = (state == arf_pkg::ARF_IDLE);
  wire start_now  = in_idle & sel_rise;
  // an edge while a conversion runs cannot start another one
  wire lost_edge  = ~in_idle & sel_rise;
  wire miss_clear = wr_status & reg_wdata[`ARF_STAT_MISS];

  // sequencer next state
  always_comb begin
    next_state = state;
    case (state)
      arf_pkg::ARF_IDLE: begin
        if (sel_rise) begin
          next_state = arf_pkg::ARF_WAIT;
        end
      end
      arf_pkg::ARF_WAIT: begin
        if (conv_done) begin
          next_state = arf_pkg::ARF_IDLE;
        end
      end
      default: begin
        next_state = arf_pkg::ARF_IDLE;
      end
    endcase
  end

  // sequencer and start pulse
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= arf_pkg::ARF_IDLE;
      conv_start <= 1'b0;
      conv_busy  <= 1'b0;
    end else begin
      state      <= next_state;
      conv_start <= start_now;
      conv_busy  <= (next_state == arf_pkg::ARF_WAIT);
    end
  end

  // ==================================================================
  // control registers
  // only the low select bits are stored
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      trig_sel <= `ARF_TRIG_RST;
      justify  <= `ARF_JUSTIFY_RST;
    end else begin
      if (wr_trig) begin
        trig_sel <= reg_wdata[`ARF_TRIG_SEL];
      end
      if (wr_format) begin
        justify <= reg_wdata[`ARF_FMT_JUSTIFY];
      end
    end
  end

  // missed-trigger flag: set beats a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      miss <= 1'b0;
    end else begin
      miss <= lost_edge | (miss & ~miss_clear);
    end
  end

  // ==================================================================
  // result bytes
  // kept off the reset tree so a warm reset leaves the last result
  // no reset: power-up value unknown, kept over sys_rst
  // completion loads both bytes and wins over a write
  always_ff @(posedge clk) begin
    if (conv_done) begin
      res_high <= core.high;
      res_low  <= core.low;
    end else begin
      if (wr_high) begin
        res_high <= reg_wdata;
      end
      if (wr_low) begin
        res_low <= reg_wdata;
      end
    end
  end

  // ==================================================================
  // read back
  // upper trigger bits read zero
  wire [7:0] rd_trig   = {`ARF_PAD4, trig_sel};
  wire [7:0] rd_format = {justify, `ARF_PAD7};
  wire [7:0] rd_status = {`ARF_PAD6, miss, conv_busy};
  wire [7:0] rd_mux    = hit_trig   ? rd_trig   :
                         hit_high   ? res_high  :
                         hit_low    ? res_low   :
                         hit_format ? rd_format :
                         hit_status ? rd_status : `ARF_DATA_IDLE;

  // data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `ARF_DATA_IDLE;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : `ARF_DATA_IDLE;
    end
  end

  // ==================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // a result byte is known once it was loaded; before that it is x
  logic high_known;
  logic low_known;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_known <= 1'b0;
      low_known  <= 1'b0;
    end else begin
      high_known <= high_known | conv_done | wr_high;
      low_known  <= low_known | conv_done | wr_low;
    end
  end

  sel_write_a: assert property (
    wr_trig |=> trig_sel == $past(reg_wdata[`ARF_TRIG_SEL]))
    else $error("trigger select not taken from write");

  trig_upper_zero_a: assert property (
    (reg_rd && hit_trig) |=> reg_rdata[7:4] == `ARF_PAD4)
    else $error("upper trigger select bits read non-zero");

  edge_start_a: assert property (
    (!$past(sys_rst) && in_idle && $stable(trig_sel)
     && !$past(trig_src[trig_sel])
     && trig_src[trig_sel]) |=> conv_start)
    else $error("rising edge on selected source gave no start");

  level_no_start_a: assert property (
    ($stable(trig_sel) && $past(trig_src[trig_sel])) |=> !conv_start)
    else $error("held level started a conversion");

  left_high_a: assert property (
    (conv_done && !justify) |=> res_high == $past(conv_value[`ARF_LJ_HIGH]))
    else $error("left justified high byte wrong");

  left_low_a: assert property (
    (conv_done && !justify) |=>
      res_low == {$past(conv_value[`ARF_LJ_LOW]), `ARF_PAD6})
    else $error("left justified low byte wrong");

  right_high_a: assert property (
    (conv_done && justify) |=>
      res_high == {`ARF_PAD6, $past(conv_value[`ARF_RJ_HIGH])})
    else $error("right justified high byte wrong");

  right_low_a: assert property (
    (conv_done && justify) |=> res_low == $past(conv_value[`ARF_RJ_LOW]))
    else $error("right justified low byte wrong");

  result_hold_a: assert property (
    (high_known && !conv_done && !wr_high) |=> $stable(res_high))
    else $error("high result byte changed without cause");

  result_write_a: assert property (
    (wr_low && !conv_done) |=> res_low == $past(reg_wdata))
    else $error("low result byte write lost");

  done_over_write_a: assert property (
    (conv_done && wr_high && !justify) |=>
      res_high == $past(conv_value[`ARF_LJ_HIGH]))
    else $error("write beat a completing conversion");

  busy_span_a: assert property (
    conv_start |-> conv_busy until_with conv_done)
    else $error("busy dropped before completion");

  read_slot_a: assert property (
    !reg_rd |=> reg_rdata == `ARF_DATA_IDLE)
    else $error("read data outside its slot");

  miss_set_a: assert property (
    lost_edge |=> miss)
    else $error("missed trigger not flagged");

  // ==================================================================
  // register side and sequencer checks
  sel_hold_a: assert property (
    !wr_trig |=> $stable(trig_sel))
    else $error("trigger select changed without a write");

  trig_read_a: assert property (
    (reg_rd && hit_trig) |=> reg_rdata[`ARF_TRIG_SEL] == $past(trig_sel))
    else $error("trigger select read back wrong");

  fmt_write_a: assert property (
    wr_format |=> justify == $past(reg_wdata[`ARF_FMT_JUSTIFY]))
    else $error("format bit not taken from write");

  fmt_read_a: assert property (
    (reg_rd && hit_format) |=> reg_rdata[`ARF_FMT_JUSTIFY] == $past(justify))
    else $error("format bit read back wrong");

  idle_start_a: assert property (
    !in_idle |=> !conv_start)
    else $error("start raised while a conversion ran");

  start_pulse_a: assert property (
    conv_start |-> conv_busy ##1 !conv_start)
    else $error("start pulse too long or without busy");

  busy_end_a: assert property (
    (conv_busy && conv_done) |=> !conv_busy)
    else $error("busy stayed up after completion");

  busy_state_a: assert property (
    conv_busy == (state == arf_pkg::ARF_WAIT))
    else $error("busy flag disagrees with sequencer");

  state_hot_a: assert property (
    $onehot(state))
    else $error("sequencer state not one-hot");

  low_hold_a: assert property (
    (low_known && !conv_done && !wr_low) |=> $stable(res_low))
    else $error("low result byte changed without cause");

  high_write_a: assert property (
    (wr_high && !conv_done) |=> res_high == $past(reg_wdata))
    else $error("high result byte write lost");

  miss_clear_a: assert property (
    (miss_clear && !lost_edge) |=> !miss)
    else $error("missed-trigger flag did not clear");

  miss_keep_a: assert property (
    (miss && !miss_clear) |=> miss)
    else $error("missed-trigger flag dropped by itself");

  unmapped_read_a: assert property (
    (reg_rd && hit_none) |=> reg_rdata == `ARF_DATA_IDLE)
    else $error("unmapped address read non-zero");

  start_c: cover property (conv_start ##[1:20] conv_done);
  left_c:  cover property (conv_done && !justify);
  right_c: cover property (conv_done && justify);
  miss_c:  cover property (lost_edge && miss_clear);
  clash_c: cover property (conv_done && (wr_high || wr_low));

endmodule

`default_nettype wire

// ==== verif/tb_top.sv ====
// self-checking bench for the result formatting and trigger block
// assumes: design files compiled first, arf_defs.svh on the include path
`timescale 1ns/100ps
`default_nettype none
`include "arf_defs.svh"

module tb_top;

  // ==========================================================
  // clock, reset and design ports
  logic        clk        = 1'b0;
  logic        sys_rst    = 1'b1;
  logic [2:0]  reg_addr   = 3'h0;
  logic [7:0]  reg_wdata  = 8'h00;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [7:0]  reg_rdata;
  logic [15:0] trig_src   = 16'h0000;
  logic        conv_start;
  logic        conv_busy;
  logic        conv_done  = 1'b0;
  logic [9:0]  conv_value = 10'h000;
  logic [7:0]  q;
  logic [9:0]  vals [4]   = '{10'h3ff, 10'h000, 10'h2d6, 10'h159};
  int          num_errors = 0;
  int          n_tests    = 0;

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  arf_result_trigger #(.SEL_W(4), .RES_W(10)) i_arf_result_trigger (
    .clk        (clk),
    .sys_rst    (sys_rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .trig_src   (trig_src),
    .conv_start (conv_start),
    .conv_busy  (conv_busy),
    .conv_done  (conv_done),
    .conv_value (conv_value)
  );

  // ==========================================================
  // shared compare, bus and converter tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  // one-cycle write strobe, data taken at the next edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // completion pulse; value goes stale afterwards so a late capture shows
  task automatic done(input logic [9:0] v);
    @(posedge clk);
    conv_done  <= 1'b1;
    conv_value <= v;
    @(posedge clk);
    conv_done  <= 1'b0;
    conv_value <= ~v;
  endtask

  // no start pulse may appear for n cycles
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      #1;
      check({7'h00, conv_start}, 8'h00);
    end
  endtask

  // single exit point for the main sequence and the watchdog
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #50000;
    num_errors++;
    stop_test();
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    // upper select bits are not stored, unmapped space reads zero
    rdc(3'h0, 8'h00);
    wr(3'h0, 8'hf9);
    rdc(3'h0, 8'h09);
    rdc(3'h5, 8'h00);
    // packing in both formats, unused bits come back as zero
    for (int f = 0; f < 2; f++) begin
      wr(3'h3, (f == 1) ? 8'h80 : 8'h00);
      rdc(3'h3, (f == 1) ? 8'h80 : 8'h00);
      foreach (vals[i]) begin
        done(vals[i]);
        if (f == 0) begin
          rdc(3'h1, vals[i][9:2]);
          rdc(3'h2, {vals[i][1:0], 6'h00});
        end else begin
          rdc(3'h1, {6'h00, vals[i][9:8]});
          rdc(3'h2, vals[i][7:0]);
        end
      end
    end
    // format change alone must not repack a stored result
    wr(3'h3, 8'h00);
    rdc(3'h1, {6'h00, vals[3][9:8]});
    // completion and a software write in one cycle: completion wins
    fork
      wr(3'h1, 8'h55);
      done(vals[2]);
    join
    rdc(3'h1, vals[2][9:2]);
    // software access, then kept through a mid-run reset
    wr(3'h1, 8'ha5);
    wr(3'h2, 8'h3c);
    rdc(3'h1, 8'ha5);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rdc(3'h1, 8'ha5);
    rdc(3'h2, 8'h3c);
    rdc(3'h0, 8'h00);
    // every select code: other sources rising start nothing,
    // the chosen one starts once, a held level never restarts
    for (int s = 0; s < 16; s++) begin
      wr(3'h0, 8'(s));
      @(posedge clk);
      trig_src <= ~(16'h0001 << s);
      quiet(3);
      trig_src <= 16'hffff;
      @(posedge clk);
      #1;
      check({7'h00, conv_start}, 8'h01);
      check({7'h00, conv_busy}, 8'h01);
      rdc(3'h4, 8'h01);
      quiet(4);
      done(vals[2]);
      #1;
      check({7'h00, conv_busy}, 8'h00);
      quiet(2);
      trig_src <= 16'h0000;
    end
    rdc(3'h1, vals[2][9:2]);
    // an edge while busy sets the missed flag, even against a clear
    @(posedge clk);
    trig_src <= 16'hffff;
    @(posedge clk);
    trig_src <= 16'h0000;
    fork
      wr(3'h4, 8'h02);
      begin
        @(posedge clk);
        trig_src <= 16'hffff;
      end
    join
    rdc(3'h4, 8'h03);
    wr(3'h4, 8'h02);
    rdc(3'h4, 8'h01);
    done(vals[0]);
    rdc(3'h4, 8'h00);
    rdc(3'h2, {vals[0][1:0], 6'h00});
    stop_test();
  end

endmodule

`default_nettype wire
